// file: inc/bam_link_if.sv
`timescale 1ns/1ps

interface bam_link_if;
    logic                  req;      // operation issue strobe
    bam_pkg::bam_op_t      op;       // operation code
    logic                  rung;     // rung condition of the issue
    logic [31:0]           operand;  // operand value
    logic                  done;     // operation consumed
    logic                  wb_valid; // memory write-back request
    logic [15:0]           wb_data;  // memory write-back word
    logic [31:0]           acc;      // accumulator
    logic [31:0]           stack1;   // first stack level
    logic [5:0]            flags;    // status flags

    modport dev (
        input  req, op, rung, operand,
        output done, wb_valid, wb_data, acc, stack1, flags
    );

    modport seq (
        output req, op, rung, operand,
        input  done, wb_valid, wb_data, acc, stack1, flags
    );
endinterface

// file: inc/bam_params.svh
`ifndef BAM_PARAMS_SVH
`define BAM_PARAMS_SVH

// register offsets of the sequencer end (byte addresses, one word each)
`define BAM_REG_CTRL      8'h00
`define BAM_REG_OPERAND   8'h04
`define BAM_REG_MEM_ADDR  8'h08
`define BAM_REG_MEM_DATA  8'h0C
`define BAM_REG_STATUS    8'h10
`define BAM_REG_ACC       8'h14
`define BAM_REG_STACK     8'h18
`define BAM_REG_INT_STAT  8'h1C
`define BAM_REG_INT_MASK  8'h20

// control register fields
`define BAM_CTRL_OP_MSB   2
`define BAM_CTRL_RUNG     3
`define BAM_CTRL_MEM      4
`define BAM_CTRL_GO       8
`define BAM_CTRL_BUSY     31

// status flag positions
`define BAM_FLG_W         6
`define BAM_FLG_ZERO      0
`define BAM_FLG_SBOR      1
`define BAM_FLG_LBOR      2
`define BAM_FLG_NEG       3
`define BAM_FLG_BCD       4
`define BAM_FLG_RANGE     5

// interrupt event positions
`define BAM_EV_W          3
`define BAM_EV_DONE       0
`define BAM_EV_BCD        1
`define BAM_EV_RANGE      2

// arithmetic constants
`define BAM_BCD8_MOD      28'h5F5E100
`define BAM_SHIFT_MAX     6'h20
`define BAM_MEM_AW        4
`define BAM_MEM_DEPTH     16

// reset values
`define BAM_ACC_RST       32'h00000000
`define BAM_FLG_RST       6'h00
`define BAM_MASK_RST      3'h0

`endif

// file: inc/bam_pkg.sv
package bam_pkg;

    // operations the sequencer can issue
    typedef enum logic [2:0] {
        acc_load_op,
        double_subtract_op,
        multiply_op,
        divide_op,
        binary_increment_op,
        binary_decrement_op,
        left_shift_op
    } bam_op_t;

    // sequencer states
    typedef enum logic [1:0] {
        seq_idle,
        seq_issue,
        seq_wait
    } bam_seq_state_t;

endpackage

// file: sim/bam_checker.sv
`timescale 1ns/1ps

module bam_checker (
    input wire logic        pclk,     // clock
    input wire logic        presetn,  // reset, active low
    input wire logic        req,      // issue
    input bam_pkg::bam_op_t op,       // op code
    input wire logic        rung,     // rung
    input wire logic [31:0] operand,  // operand
    input wire logic        done,     // done pulse
    input wire logic        wb_valid, // write-back
    input wire logic [15:0] wb_data,  // write-back word
    input wire logic [31:0] acc,      // accumulator
    input wire logic [31:0] stack1,   // stack level 1
    input wire logic [5:0]  flags     // flags
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // an issue of one operation with its rung true
    sequence s_run(bam_pkg::bam_op_t o);
        req && rung && op == o;
    endsequence
    // completion free of digit and range faults
    sequence s_clean;
        done && !flags[4] && !flags[5];
    endsequence
    property p_done; req |=> done; endproperty
    a_done: assert property (p_done) else $error("no done");
    property p_idle;
        !req |=> !done && $stable(acc) && $stable(stack1) && $stable(flags);
    endproperty
    a_idle: assert property (p_idle) else $error("idle change");
    property p_norung;
        req && !rung |=> $stable(acc) && $stable(flags) && !wb_valid;
    endproperty
    a_norung: assert property (p_norung) else $error("rung off");
    property p_shift;
        s_run(bam_pkg::left_shift_op) ##0 (operand[5:0] inside {[1:32]})
        |=> acc == $past(acc) << $past(operand[5:0]);
    endproperty
    a_shift: assert property (p_shift) else $error("shift");
    property p_inc;
        s_run(bam_pkg::binary_increment_op)
        |=> wb_valid && flags[0] == !wb_data;
    endproperty
    a_inc: assert property (p_inc) else $error("increment");
    property p_dec;
        s_run(bam_pkg::binary_decrement_op)
        |=> wb_valid && flags[0] == !wb_data;
    endproperty
    a_dec: assert property (p_dec) else $error("decrement");
    property p_zero;
        s_run(bam_pkg::multiply_op) ##1 s_clean |-> flags[0] == !acc;
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag");
    property p_neg; s_run(bam_pkg::divide_op) ##1 s_clean |-> !flags[3];
    endproperty
    a_neg: assert property (p_neg) else $error("negative");
    property p_borrow;
        s_run(bam_pkg::double_subtract_op) ##1 s_clean
        |-> flags[2] == flags[3];
    endproperty
    a_borrow: assert property (p_borrow) else $error("borrow");
endmodule

// file: sim/bam_math_unit_tb.sv
`timescale 1ns/1ps
`include "bam_params.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
    $display("mismatch %0t %0h %0h", $time, a, b); end end

module bam_math_unit_tb;
    logic        pclk = 0, presetn = 0;           // clock, reset
    logic        psel = 0, penable = 0, pwrite = 0; // apb request
    logic [7:0]  paddr = 0;                       // apb address
    logic [31:0] pwdata = 0, prdata, rd;          // apb data, last read
    logic        pready, pslverr, irq, err;       // apb answer, interrupt
    logic [5:0]  sf;                              // live flags
    int          mismatches = 0, cmp_count = 0;   // counters
    bam_link_if lnk ();
    bam_math_unit i_bam_math_unit (.pclk(pclk), .presetn(presetn), .lnk(lnk),
        .status_flags(sf));
    bam_sequencer i_bam_sequencer (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .lnk(lnk));
    bam_checker i_bam_checker (.pclk(pclk), .presetn(presetn), .req(lnk.req),
        .op(lnk.op), .rung(lnk.rung), .operand(lnk.operand), .done(lnk.done),
        .wb_valid(lnk.wb_valid), .wb_data(lnk.wb_data), .acc(lnk.acc),
        .stack1(lnk.stack1), .flags(lnk.flags));
    initial forever #2.5 pclk = ~pclk;
    // one transfer; answer taken at the edge that sees pready high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // issue with a constant, poll busy, leave the accumulator in rd
    task automatic run(input bam_pkg::bam_op_t o, input logic r,
                       input logic [31:0] k);
        apb(1'b1, `BAM_REG_OPERAND, k);
        apb(1'b1, `BAM_REG_CTRL, 32'h100 | {28'h0, r, o});
        rd = 32'h80000000;
        while (rd[31]) apb(1'b0, `BAM_REG_CTRL, 32'h0);
        apb(1'b0, `BAM_REG_ACC, 32'h0);
    endtask
    task t_mul_sub;
        run(bam_pkg::acc_load_op, 1'b1, 32'h00001234);
        run(bam_pkg::multiply_op, 1'b1, 32'h00000003);
        `CHK(rd, 32'h00003702)
        run(bam_pkg::double_subtract_op, 1'b1, 32'h00003702);
        `CHK(rd, 32'h00000000)
        `CHK(sf, 6'h01)
    endtask
    // borrow through all eight digits; divide keeps the borrow flags
    task t_borrow_div;
        run(bam_pkg::acc_load_op, 1'b1, 32'h00000005);
        run(bam_pkg::double_subtract_op, 1'b1, 32'h00000010);
        `CHK(rd, 32'h99999995)
        `CHK(sf, 6'h0E)
        run(bam_pkg::acc_load_op, 1'b1, 32'h00000017);
        run(bam_pkg::divide_op, 1'b1, 32'h00000005);
        `CHK(rd, 32'h00000003)
        `CHK(sf, 6'h06)
        apb(1'b0, `BAM_REG_STACK, 32'h0);
        `CHK(rd, 32'h00000002)
    endtask
    // faulty operands and a false rung leave the accumulator alone
    task t_faults;
        run(bam_pkg::divide_op, 1'b1, 32'h00000000);
        `CHK({rd[3:0], sf[5]}, 5'h07)
        run(bam_pkg::multiply_op, 1'b1, 32'h0000000A);
        `CHK({rd[3:0], sf[4]}, 5'h07)
        run(bam_pkg::double_subtract_op, 1'b0, 32'h00000001);
        `CHK(rd, 32'h00000003)
    endtask
    // memory word wraps up through zero and back down
    task t_incdec;
        apb(1'b1, `BAM_REG_MEM_ADDR, 32'h3);
        apb(1'b1, `BAM_REG_MEM_DATA, 32'hFFFF);
        run(bam_pkg::binary_increment_op, 1'b1, 32'h0);
        apb(1'b0, `BAM_REG_MEM_DATA, 32'h0);
        `CHK({rd, sf[0]}, 33'h1)
        run(bam_pkg::binary_decrement_op, 1'b1, 32'h0);
        apb(1'b0, `BAM_REG_MEM_DATA, 32'h0);
        `CHK({rd, sf[0]}, 33'h1FFFE)
    endtask
    task t_shift;
        run(bam_pkg::acc_load_op, 1'b1, 32'h80000001);
        run(bam_pkg::left_shift_op, 1'b1, 32'h00000001);
        `CHK(rd, 32'h00000002)
        run(bam_pkg::left_shift_op, 1'b1, 32'h00000020);
        `CHK(rd, 32'h00000000)
    endtask
    // events stick, the mask gates the line, a one clears; unmapped errs
    task t_irq;
        apb(1'b0, `BAM_REG_INT_STAT, 32'h0);
        `CHK({rd, irq}, 33'hE)
        apb(1'b1, `BAM_REG_INT_MASK, 32'h1);
        apb(1'b0, `BAM_REG_INT_MASK, 32'h0);
        `CHK({rd, irq}, 33'h3)
        apb(1'b1, `BAM_REG_INT_STAT, 32'h7);
        apb(1'b0, 8'h40, 32'h0);
        `CHK({rd, err, irq}, 34'h2)
    endtask
    task end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_mul_sub();
        t_borrow_div();
        t_faults();
        t_incdec();
        t_shift();
        t_irq();
        end_of_test();
    end
    // about 15 operations of some 16 cycles each fit well inside this
    initial begin
        #100000;
        mismatches++;
        end_of_test();
    end
endmodule

// file: src/bam_math_unit.sv
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "bam_params.svh"

// Behaviour
// - double subtract takes 32-bit BCD from accumulator
// - subtract constant limited to eight BCD digits
// - zero flag when result is zero
// - borrow flags for 16 and 32 bits
// - negative flag when accumulator goes negative
// - invalid-BCD flag on illegal operand digit
// - flags valid until next flag-writing operation
// - multiply low 16 bits, 8-digit product
// - multiply/divide operand at most four digits
// - divide, quotient to accumulator, remainder stacked
// - range flag when divide operand unusable
// - increment memory word, write back, zero flag
// - decrement memory word, write back, zero flag
// - left shift with zero fill, top lost
// - shift count is one to thirty-two (unit takes 0 to 63: 0 keeps the accumulator, 32 and above clear it)
module bam_math_unit (
    input  wire logic   pclk,         // system clock
    input  wire logic   presetn,      // async reset, active low
    bam_link_if.dev     lnk,          // sequencer link
    output logic [5:0]  status_flags  // live copy of the flags
);

    // packed BCD to binary, eight digits
    function automatic logic [26:0] bcd_to_bin(input logic [31:0] v);
        logic [26:0] s;
        s = 27'h0000000;
        for (int i = 7; i >= 0; i--) begin
            s = 27'(s * 27'h000000A) + 27'(v[i*4 +: 4]);
        end
        return s;
    endfunction

    // binary to packed BCD by shift-and-add-three
    function automatic logic [31:0] bin_to_bcd(input logic [26:0] v);
        logic [31:0] r;
        r = 32'h00000000;
        for (int i = 26; i >= 0; i--) begin
            for (int d = 0; d < 8; d++) begin
                if (r[d*4 +: 4] > 4'h4) begin
                    r[d*4 +: 4] = r[d*4 +: 4] + 4'h3;
                end
            end
            r = {r[30:0], v[i]};
        end
        return r;
    endfunction

    // every nibble a legal decimal digit
    function automatic logic bcd_ok(input logic [31:0] v);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < 8; i++) begin
            if (v[i*4 +: 4] > 4'h9) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    logic [31:0] acc;            // accumulator
    logic [31:0] stack1;         // first stack level
    logic [5:0]  flags;          // status flags
    logic        done;           // consumed strobe
    logic        wb_valid;       // write-back strobe
    logic [15:0] wb_data;        // write-back word
    logic [31:0] next_acc;       // accumulator next value
    logic [31:0] next_stack;     // stack next value
    logic [5:0]  next_flags;     // flags next value
    logic        next_wb_valid;  // write-back next value
    logic [15:0] next_wb_data;   // write-back word next value

    logic [26:0] acc_bin;        // whole accumulator, binary
    logic [26:0] opd_bin;        // whole operand, binary
    logic [26:0] acc_lo_bin;     // low four accumulator digits
    logic [26:0] opd_lo_bin;     // low four operand digits
    logic [27:0] diff;           // raw difference, top bit is borrow
    logic [26:0] sub_res;        // ten's complement difference
    logic [26:0] product;        // four by four digit product
    logic [26:0] divisor;        // divisor kept nonzero
    logic [26:0] quotient;       // divide quotient
    logic [26:0] remainder;      // divide remainder
    logic        full_ok;        // both whole values are BCD
    logic        lo_ok;          // both low halves are BCD
    logic        div_ok;         // dividend and divisor are BCD
    logic [15:0] inc_word;       // memory word plus one
    logic [15:0] dec_word;       // memory word minus one
    logic [5:0]  shift_cnt;      // requested shift count

    // decimal views of the operands
    assign acc_bin    = bcd_to_bin(acc);
    assign opd_bin    = bcd_to_bin(lnk.operand);
    assign acc_lo_bin = bcd_to_bin({16'h0000, acc[15:0]});
    assign opd_lo_bin = bcd_to_bin({16'h0000, lnk.operand[15:0]});
    assign full_ok    = bcd_ok(acc) && bcd_ok(lnk.operand);
    assign lo_ok      = bcd_ok({16'h0000, acc[15:0]})
                     && bcd_ok({16'h0000, lnk.operand[15:0]});
    assign div_ok     = bcd_ok(acc)
                     && bcd_ok({16'h0000, lnk.operand[15:0]});

    // subtract wraps modulo 10^8 so a negative result stays legal BCD
    assign diff    = {1'b0, acc_bin} - {1'b0, opd_bin};
    assign sub_res = diff[27] ? 27'(diff + `BAM_BCD8_MOD)
                              : diff[26:0];

    // only the low 16 operand bits take part in multiply and divide
    assign product   = 27'(acc_lo_bin * opd_lo_bin);
    // a zero divisor is replaced so simulation never sees unknowns
    assign divisor   = (opd_lo_bin == 27'h0000000) ? 27'h0000001
                                                   : opd_lo_bin;
    assign quotient  = acc_bin / divisor;
    assign remainder = acc_bin % divisor;

    // binary memory arithmetic wraps at 16 bits
    assign inc_word  = lnk.operand[15:0] + 16'h0001;
    assign dec_word  = lnk.operand[15:0] - 16'h0001;
    assign shift_cnt = lnk.operand[5:0];

    // operation decode; nothing moves without an issue with rung true
    always_comb begin
        next_acc      = acc;
        next_stack    = stack1;
        next_flags    = flags;
        next_wb_valid = 1'b0;
        next_wb_data  = wb_data;
        if (lnk.req && lnk.rung) begin
            case (lnk.op)
                bam_pkg::acc_load_op: begin
                    // plain load, touches no flags
                    next_acc = lnk.operand;
                end
                bam_pkg::double_subtract_op: begin
                    if (!full_ok) begin
                        // bad digit: flag it, keep the accumulator
                        next_flags[`BAM_FLG_BCD] = 1'b1;
                    end else begin
                        next_acc = bin_to_bcd(sub_res);
                        next_flags[`BAM_FLG_BCD]  = 1'b0;
                        next_flags[`BAM_FLG_ZERO] =
                            (sub_res == 27'h0000000);
                        next_flags[`BAM_FLG_SBOR] =
                            (acc_lo_bin < opd_lo_bin);
                        next_flags[`BAM_FLG_LBOR] = diff[27];
                        next_flags[`BAM_FLG_NEG]  = diff[27];
                    end
                end
                bam_pkg::multiply_op: begin
                    if (!lo_ok) begin
                        next_flags[`BAM_FLG_BCD] = 1'b1;
                    end else begin
                        next_acc = bin_to_bcd(product);
                        next_flags[`BAM_FLG_BCD]  = 1'b0;
                        next_flags[`BAM_FLG_ZERO] =
                            (product == 27'h0000000);
                        // unsigned BCD product is never negative
                        next_flags[`BAM_FLG_NEG]  = 1'b0;
                    end
                end
                bam_pkg::divide_op: begin
                    if (!div_ok) begin
                        next_flags[`BAM_FLG_BCD] = 1'b1;
                    end else if (opd_lo_bin == 27'h0000000) begin
                        // zero divisor cannot be processed
                        next_flags[`BAM_FLG_BCD]   = 1'b0;
                        next_flags[`BAM_FLG_RANGE] = 1'b1;
                    end else begin
                        next_acc   = bin_to_bcd(quotient);
                        next_stack = bin_to_bcd(remainder);
                        next_flags[`BAM_FLG_BCD]   = 1'b0;
                        next_flags[`BAM_FLG_RANGE] = 1'b0;
                        next_flags[`BAM_FLG_ZERO]  =
                            (quotient == 27'h0000000);
                        next_flags[`BAM_FLG_NEG]   = 1'b0;
                    end
                end
                bam_pkg::binary_increment_op: begin
                    next_wb_valid = 1'b1;
                    next_wb_data  = inc_word;
                    next_flags[`BAM_FLG_ZERO] =
                        (inc_word == 16'h0000);
                end
                bam_pkg::binary_decrement_op: begin
                    next_wb_valid = 1'b1;
                    next_wb_data  = dec_word;
                    next_flags[`BAM_FLG_ZERO] =
                        (dec_word == 16'h0000);
                end
                bam_pkg::left_shift_op: begin
                    // count of 32 or more empties the accumulator
                    if (shift_cnt >= `BAM_SHIFT_MAX) begin
                        next_acc = 32'h00000000;
                    end else begin
                        next_acc = acc << shift_cnt;
                    end
                end
                default: begin
                    // unknown code: consumed, nothing changes
                end
            endcase
        end
    end

    // accumulator and stack
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc    <= `BAM_ACC_RST;
            stack1 <= `BAM_ACC_RST;
        end else begin
            acc    <= next_acc;
            stack1 <= next_stack;
        end
    end

    // flags are simply overwritten by the next op that writes them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= `BAM_FLG_RST;
        end else begin
            flags <= next_flags;
        end
    end

    // answer strobes one cycle after an issue: done after every issue, write-back only after a rung-true increment or decrement
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done     <= 1'b0;
            wb_valid <= 1'b0;
            wb_data  <= 16'h0000;
        end else begin
            done     <= lnk.req;
            wb_valid <= next_wb_valid;
            wb_data  <= next_wb_data;
        end
    end

    // all link outputs come straight from the flops above
    assign lnk.done     = done;
    assign lnk.wb_valid = wb_valid;
    assign lnk.wb_data  = wb_data;
    assign lnk.acc      = acc;
    assign lnk.stack1   = stack1;
    assign lnk.flags    = flags;
    assign status_flags = flags;

endmodule

// file: src/bam_sequencer.sv
`timescale 1ns/1ps
`include "bam_params.svh"

module bam_sequencer (
    input  wire logic         pclk,     // system clock
    input  wire logic         presetn,  // async reset, active low
    input  wire logic         psel,     // apb select
    input  wire logic         penable,  // apb access phase
    input  wire logic         pwrite,   // apb direction
    input  wire logic [7:0]   paddr,    // apb byte address
    input  wire logic [31:0]  pwdata,   // apb write data
    output logic [31:0]       prdata,   // apb read data
    output logic              pready,   // apb ready
    output logic              pslverr,  // apb error, unmapped address
    output logic              irq,      // level interrupt
    bam_link_if.seq           lnk       // link to the math unit
);

    bam_pkg::bam_seq_state_t state;               // issue state
    logic [2:0]              ctrl_op;             // selected op code
    logic                    ctrl_rung;           // rung condition
    logic                    ctrl_mem;            // operand from memory
    logic [31:0]             operand_k;           // constant operand
    logic [`BAM_MEM_AW-1:0]  mem_addr;            // word address
    logic [15:0]             mem [`BAM_MEM_DEPTH]; // word data memory
    logic [`BAM_EV_W-1:0]    int_stat;            // sticky events
    logic [`BAM_EV_W-1:0]    int_mask;            // event enables
    logic [`BAM_EV_W-1:0]    ev;                  // events this cycle
    logic [`BAM_EV_W-1:0]    w1c;                 // clear strobes
    logic                    req;                 // issue strobe
    bam_pkg::bam_op_t        op;                  // issued op
    logic                    rung;                // issued rung
    logic [31:0]             opnd;                // issued operand
    logic                    wr;                  // apb write completes
    logic                    setup_rd;            // first access cycle
    logic                    idle;                // no op in flight
    logic                    go;                  // start request
    logic                    fin;                 // op answered
    bam_pkg::bam_op_t        go_op;               // decoded op code
    logic [31:0]             go_opnd;             // operand to issue
    logic [31:0]             rd_data;             // read mux
    logic                    rd_err;              // unmapped address

    assign idle     = (state == bam_pkg::seq_idle);
    assign wr       = psel && penable && pready && pwrite;
    assign setup_rd = psel && penable && !pready;
    assign go       = wr && (paddr == `BAM_REG_CTRL)
                   && pwdata[`BAM_CTRL_GO] && idle;
    assign fin      = (state == bam_pkg::seq_wait) && lnk.done;
    assign go_op    = bam_pkg::bam_op_t'(pwdata[`BAM_CTRL_OP_MSB:0]);

    // pick the operand: double ops take two words, low word first
    always_comb begin
        go_opnd = operand_k;
        if (pwdata[`BAM_CTRL_MEM]
            || go_op == bam_pkg::binary_increment_op
            || go_op == bam_pkg::binary_decrement_op) begin
            if (go_op == bam_pkg::double_subtract_op) begin
                go_opnd = {mem[mem_addr + 4'h1], mem[mem_addr]};
            end else begin
                go_opnd = {16'h0000, mem[mem_addr]};
            end
        end
    end

    // register read mux; flags are read live, as the unit holds them
    always_comb begin
        rd_data = 32'h00000000;
        rd_err  = 1'b0;
        case (paddr)
            `BAM_REG_CTRL: begin
                rd_data[`BAM_CTRL_OP_MSB:0] = ctrl_op;
                rd_data[`BAM_CTRL_RUNG]     = ctrl_rung;
                rd_data[`BAM_CTRL_MEM]      = ctrl_mem;
                rd_data[`BAM_CTRL_BUSY]     = !idle;
            end
            `BAM_REG_OPERAND:  rd_data = operand_k;
            `BAM_REG_MEM_ADDR: rd_data[`BAM_MEM_AW-1:0] = mem_addr;
            `BAM_REG_MEM_DATA: rd_data[15:0] = mem[mem_addr];
            `BAM_REG_STATUS:   rd_data[`BAM_FLG_W-1:0] = lnk.flags;
            `BAM_REG_ACC:      rd_data = lnk.acc;
            `BAM_REG_STACK:    rd_data = lnk.stack1;
            `BAM_REG_INT_STAT: rd_data[`BAM_EV_W-1:0] = int_stat;
            `BAM_REG_INT_MASK: rd_data[`BAM_EV_W-1:0] = int_mask;
            default:           rd_err = 1'b1;
        endcase
    end

    // apb answer: ready in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup_rd;
            pslverr <= setup_rd && rd_err;
            if (setup_rd && !pwrite) begin
                prdata <= rd_data;
            end
        end
    end

    // configuration registers; changes refused while an op is in flight
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_op   <= 3'h0;
            ctrl_rung <= 1'b0;
            ctrl_mem  <= 1'b0;
            operand_k <= 32'h00000000;
            mem_addr  <= 4'h0;
            int_mask  <= `BAM_MASK_RST;
        end else if (wr && idle) begin
            case (paddr)
                `BAM_REG_CTRL: begin
                    ctrl_op   <= pwdata[`BAM_CTRL_OP_MSB:0];
                    ctrl_rung <= pwdata[`BAM_CTRL_RUNG];
                    ctrl_mem  <= pwdata[`BAM_CTRL_MEM];
                end
                `BAM_REG_OPERAND:  operand_k <= pwdata;
                `BAM_REG_MEM_ADDR: mem_addr <= pwdata[`BAM_MEM_AW-1:0];
                `BAM_REG_INT_MASK: int_mask <= pwdata[`BAM_EV_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // data memory: write-back from the unit beats software access
    always_ff @(posedge pclk) begin
        if (fin && lnk.wb_valid) begin
            mem[mem_addr] <= lnk.wb_data;
        end else if (wr && idle && paddr == `BAM_REG_MEM_DATA) begin
            mem[mem_addr] <= pwdata[15:0];
        end
    end

    // issue sequence: one req pulse, then wait for done
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= bam_pkg::seq_idle;
            req   <= 1'b0;
            op    <= bam_pkg::acc_load_op;
            rung  <= 1'b0;
            opnd  <= 32'h00000000;
        end else begin
            case (state)
                bam_pkg::seq_idle: begin
                    if (go) begin
                        state <= bam_pkg::seq_issue;
                        req   <= 1'b1;
                        op    <= go_op;
                        rung  <= pwdata[`BAM_CTRL_RUNG];
                        opnd  <= go_opnd;
                    end
                end
                bam_pkg::seq_issue: begin
                    req   <= 1'b0;
                    state <= bam_pkg::seq_wait;
                end
                bam_pkg::seq_wait: begin
                    if (lnk.done) begin
                        state <= bam_pkg::seq_idle;
                    end
                end
                default: begin
                    req   <= 1'b0;
                    state <= bam_pkg::seq_idle;
                end
            endcase
        end
    end

    // events and write-one-to-clear; a new event beats its clear
    assign ev[`BAM_EV_DONE]  = fin;
    assign ev[`BAM_EV_BCD]   = fin && lnk.flags[`BAM_FLG_BCD];
    assign ev[`BAM_EV_RANGE] = fin && lnk.flags[`BAM_FLG_RANGE];
    assign w1c = (wr && paddr == `BAM_REG_INT_STAT)
               ? pwdata[`BAM_EV_W-1:0] : 3'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat <= 3'h0;
            irq      <= 1'b0;
        end else begin
            int_stat <= (int_stat & ~w1c) | ev;
            irq      <= |(int_stat & int_mask);
        end
    end

    assign lnk.req     = req;
    assign lnk.op      = op;
    assign lnk.rung    = rung;
    assign lnk.operand = opnd;

endmodule
